// ==== cag_pkg.sv ====
// Constants and types for the address generation and bus cycle block
package cag_pkg;

    // Addressing modes
    typedef enum logic [3:0] {
        CAG_AM_REG_DIRECT,
        CAG_AM_REG_INDIRECT,
        CAG_AM_DISP16,
        CAG_AM_DISP24,
        CAG_AM_POST_INC,
        CAG_AM_PRE_DEC,
        CAG_AM_ABS8,
        CAG_AM_ABS16,
        CAG_AM_ABS24,
        CAG_AM_IMM,
        CAG_AM_PC_REL8,
        CAG_AM_PC_REL16,
        CAG_AM_MEM_INDIRECT
    } cag_mode_t;

    // Operand sizes
    localparam logic [1:0] CAG_SZ_BYTE = 2'h0;
    localparam logic [1:0] CAG_SZ_WORD = 2'h1;
    localparam logic [1:0] CAG_SZ_LONG = 2'h2;

    // Bit modify operations
    localparam logic [2:0] CAG_BOP_NONE     = 3'h0;
    localparam logic [2:0] CAG_BOP_SET      = 3'h1;
    localparam logic [2:0] CAG_BOP_CLEAR    = 3'h2;
    localparam logic [2:0] CAG_BOP_INVERT   = 3'h3;
    localparam logic [2:0] CAG_BOP_STORE    = 3'h4;
    localparam logic [2:0] CAG_BOP_INV_STORE = 3'h5;

    // Target kinds
    localparam logic [1:0] CAG_TGT_MEM    = 2'h0;
    localparam logic [1:0] CAG_TGT_PER16  = 2'h1;
    localparam logic [1:0] CAG_TGT_PER8   = 2'h2;
    localparam logic [1:0] CAG_TGT_UNMAP  = 2'h3;

    // Address constants
    localparam logic [15:0] CAG_ABS8_UPPER   = 16'hFFFF;
    localparam logic [7:0]  CAG_EXT24_UPPER  = 8'h00;
    localparam logic [7:0]  CAG_MIND_UPPER   = 8'h00;
    localparam logic [31:0] CAG_INC_BYTE     = 32'h0000_0001;
    localparam logic [31:0] CAG_INC_WORD     = 32'h0000_0002;
    localparam logic [31:0] CAG_INC_LONG     = 32'h0000_0004;

    // Bus cycle lengths in states
    localparam logic [1:0] CAG_STATES_FAST = 2'h2;
    localparam logic [1:0] CAG_STATES_SLOW = 2'h3;

    // CPU top-level states and sub-modes
    typedef enum logic [1:0] {
        CAG_CPU_RESET,
        CAG_CPU_EXEC,
        CAG_CPU_HALT,
        CAG_CPU_EXCEPT
    } cag_cpu_t;

    localparam logic [1:0] CAG_SUB_ACTIVE    = 2'h0;
    localparam logic [1:0] CAG_SUB_SUBACTIVE = 2'h1;
    localparam logic [1:0] CAG_SUB_SLEEP     = 2'h0;
    localparam logic [1:0] CAG_SUB_STANDBY   = 2'h1;
    localparam logic [1:0] CAG_SUB_SUBSLEEP  = 2'h2;

endpackage

// ==== cag_bus_cycle.sv ====
// Bus cycle sequencer: two or three states per cycle, split of 8-bit words
`timescale 1ns/10ps
module cag_bus_cycle
    import cag_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        state_en_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic        word_i,
    input  wire logic [1:0]  tgt_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [15:0]      rdata_o,
    output logic [15:0]      bus_addr_o,
    output logic [15:0]      bus_wdata_o,
    output logic             bus_re_o,
    output logic             bus_we_o,
    output logic             bus_word_o,
    output logic             bus_last_o,
    input  wire logic [15:0] bus_rdata_i
);

    logic        act_q;
    logic [1:0]  cnt_q;
    logic [1:0]  len_q;
    logic        second_q;
    logic        split_q;
    logic        we_q;
    logic        word_q;
    logic        unmap_q;
    logic [15:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic        done_q;

    wire cyc_end = act_q && state_en_i && (cnt_q == len_q - 2'h1);
    wire more    = split_q && !second_q;
    wire start   = req_i && !act_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            act_q    <= 1'b0;
            cnt_q    <= 2'h0;
            len_q    <= CAG_STATES_FAST;
            second_q <= 1'b0;
            split_q  <= 1'b0;
            we_q     <= 1'b0;
            word_q   <= 1'b0;
            unmap_q  <= 1'b0;
            addr_q   <= 16'h0000;
            wdata_q  <= 16'h0000;
            rdata_q  <= 16'h0000;
            done_q   <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                act_q    <= 1'b1;
                cnt_q    <= 2'h0;
                len_q    <= (tgt_i == CAG_TGT_PER8) ? CAG_STATES_SLOW : CAG_STATES_FAST;
                split_q  <= word_i && (tgt_i == CAG_TGT_PER8);
                second_q <= 1'b0;
                we_q     <= we_i;
                word_q   <= word_i || (tgt_i == CAG_TGT_PER16);
                unmap_q  <= (tgt_i == CAG_TGT_UNMAP);
                addr_q   <= addr_i;
                wdata_q  <= wdata_i;
            end else if (act_q && state_en_i) begin
                cnt_q <= cnt_q + 2'h1;
                if (cyc_end) begin
                    cnt_q <= 2'h0;
                    if (!we_q && !split_q) begin
                        rdata_q <= unmap_q ? 16'h0000 : bus_rdata_i;
                    end else if (!we_q && !second_q) begin
                        rdata_q[15:8] <= bus_rdata_i[15:8];
                    end else if (!we_q) begin
                        rdata_q[7:0] <= bus_rdata_i[7:0];
                    end
                    if (more) begin
                        second_q <= 1'b1;
                        addr_q   <= addr_q + 16'h0001;
                    end else begin
                        act_q  <= 1'b0;
                        done_q <= 1'b1;
                    end
                end
            end
        end
    end

    assign busy_o      = act_q;
    assign done_o      = done_q;
    assign rdata_o     = rdata_q;
    assign bus_addr_o  = act_q ? addr_q : addr_i;
    assign bus_wdata_o = wdata_q;
    assign bus_re_o    = act_q && !we_q && !unmap_q;
    assign bus_we_o    = act_q && we_q && !unmap_q;
    assign bus_word_o  = word_q && !split_q;
    assign bus_last_o  = cyc_end;

endmodule // cag_bus_cycle

// ==== cag_core.sv ====
// Effective address generation, bit modify sequencing and CPU state
// What this block does
// - Register direct selects byte halves, word halves or whole 32-bit register.
// - Register indirect uses lower 24 bits of the pointer register.
// - Displacement add; 16-bit displacement sign-extended; lower 24 bits used.
// - Post-increment accesses at pointer, then adds 1, 2 or 4 back.
// - Pre-decrement subtracts 1, 2 or 4 first, stores it, uses result.
// - Absolute 8-bit extended with ones, 16-bit sign-extended, 24-bit as given.
// - 8-bit absolute reaches only the top page; 16-bit the bottom and top 32K; 24-bit the full range.
// - Immediates of 8, 16, 32 bits; 3-bit bit number; 2-bit trap vector.
// - PC relative adds sign-extended 8/16-bit displacement to 24-bit PC.
// - Memory indirect zero-extends 8-bit address and reads a longword.
// - Memory indirect drops first byte; remaining three form the target.
// - Effective addresses drop upper 8 bits; bus address is 16 bits.
// - One state per active clock edge; bus cycle two or three states.
// - On-chip memory takes two states, 16-bit path, byte or word.
// - 16-bit peripheral registers accessed by word size only.
// - Word access to an 8-bit peripheral becomes two bus cycles.
// - Two-state peripherals time like memory; others take three states.
// - CPU states reset, execution, halt, exception with their sub-modes.
// - Unmapped writes discarded, unmapped reads return zero.
// - Bit set, clear, invert, store: read byte, change bit, write back.
// - A 24-bit extension is a 32-bit value with upper byte zero.
`timescale 1ns/10ps
module cag_core
    import cag_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        state_en_i,
    input  wire logic        sub_clk_sel_i,
    input  wire logic        start_i,
    input  wire cag_mode_t   mode_i,
    input  wire logic [1:0]  size_i,
    input  wire logic [3:0]  reg_sel_i,
    input  wire logic [31:0] pointer_register_i,
    input  wire logic [31:0] ext_i,
    input  wire logic [23:0] pc_i,
    input  wire logic        we_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [2:0]  bit_op_i,
    input  wire logic [2:0]  bit_num_i,
    input  wire logic        carry_i,
    input  wire logic [7:0]  trap_opcode_i,
    input  wire logic [1:0]  tgt_i,
    input  wire logic        halt_req_i,
    input  wire logic [1:0]  halt_mode_i,
    input  wire logic        wake_i,
    input  wire logic        except_req_i,
    input  wire logic        except_done_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [31:0]      operand_o,
    output logic [23:0]      ea_o,
    output logic [23:0]      target_o,
    output logic [31:0]      ptr_wb_o,
    output logic             ptr_wb_en_o,
    output logic [31:0]      imm_o,
    output logic [1:0]       trap_vector_o,
    output logic [15:0]      rdata_o,
    output logic [15:0]      bus_addr_o,
    output logic [15:0]      bus_wdata_o,
    output logic             bus_re_o,
    output logic             bus_we_o,
    output logic             bus_word_o,
    input  wire logic [15:0] bus_rdata_i,
    input  wire logic [1:0]  bus_tgt_i,
    output logic [1:0]       cpu_state_o,
    output logic [1:0]       cpu_submode_o
);

    typedef enum logic [2:0] {
        CAG_IDLE,
        CAG_ACCESS,
        CAG_MIND_HI,
        CAG_MIND_LO,
        CAG_RMW_WRITE,
        CAG_FINISH
    } cag_seq_t;

    function automatic logic [31:0] cag_step(input logic [1:0] sz);
        cag_step = (sz == CAG_SZ_LONG) ? CAG_INC_LONG :
                   (sz == CAG_SZ_WORD) ? CAG_INC_WORD : CAG_INC_BYTE;
    endfunction

    function automatic logic [23:0] cag_sext16(input logic [15:0] v);
        cag_sext16 = {{8{v[15]}}, v};
    endfunction

    cag_seq_t    seq_q, seq_d;
    cag_cpu_t    cpu_q;
    logic [1:0]  sub_q;
    logic [23:0] ea_q;
    logic [23:0] target_q;
    logic [31:0] ptr_wb_q;
    logic        ptr_wb_en_q;
    logic [31:0] operand_q;
    logic [31:0] imm_q;
    logic [1:0]  trap_q;
    logic        done_q;
    logic [7:0]  tgt_hi_q;
    logic        we_q;
    logic        word_q;
    logic [15:0] wdata_q;
    logic [2:0]  bop_q;
    logic [2:0]  bnum_q;
    logic        carry_q;
    logic [1:0]  mode_sz_q;
    logic        post_q;
    logic [7:0]  mod_byte_q;
    logic [15:0] bc_rdata;

    // Operand register slices
    wire [7:0]  byte_sel = reg_sel_i[3] ? pointer_register_i[7:0] : pointer_register_i[15:8];
    wire [15:0] word_sel = reg_sel_i[3] ? pointer_register_i[31:16] : pointer_register_i[15:0];
    wire [31:0] reg_operand = (size_i == CAG_SZ_BYTE) ? {24'h000000, byte_sel} :
                              (size_i == CAG_SZ_WORD) ? {16'h0000, word_sel} :
                              pointer_register_i;

    // Effective address per mode
    wire [31:0] ext24     = {CAG_EXT24_UPPER, ext_i[23:0]};
    wire [23:0] ea_disp16 = pointer_register_i[23:0] + cag_sext16(ext_i[15:0]);
    wire [23:0] ea_disp24 = pointer_register_i[23:0] + ext24[23:0];
    wire [31:0] ptr_dec   = pointer_register_i - cag_step(size_i);
    wire [31:0] ptr_inc   = pointer_register_i + cag_step(size_i);
    wire [23:0] ea_abs8   = {CAG_ABS8_UPPER, ext_i[7:0]};
    wire [23:0] ea_abs16  = cag_sext16(ext_i[15:0]);
    wire [23:0] ea_pc8    = pc_i + {{16{ext_i[7]}}, ext_i[7:0]};
    wire [23:0] ea_pc16   = pc_i + cag_sext16(ext_i[15:0]);
    wire [23:0] ea_mind   = {8'h00, CAG_MIND_UPPER, ext_i[7:0]};

    logic [23:0] ea_calc;
    always_comb begin
        case (mode_i)
            CAG_AM_REG_INDIRECT: ea_calc = pointer_register_i[23:0];
            CAG_AM_POST_INC:     ea_calc = pointer_register_i[23:0];
            CAG_AM_DISP16:       ea_calc = ea_disp16;
            CAG_AM_DISP24:       ea_calc = ea_disp24;
            CAG_AM_PRE_DEC:      ea_calc = ptr_dec[23:0];
            CAG_AM_ABS8:         ea_calc = ea_abs8;
            CAG_AM_ABS16:        ea_calc = ea_abs16;
            CAG_AM_ABS24:        ea_calc = ext24[23:0];
            CAG_AM_PC_REL8:      ea_calc = ea_pc8;
            CAG_AM_PC_REL16:     ea_calc = ea_pc16;
            CAG_AM_MEM_INDIRECT: ea_calc = ea_mind;
            default:             ea_calc = 24'h000000;
        endcase
    end

    wire is_mem  = (mode_i != CAG_AM_REG_DIRECT) && (mode_i != CAG_AM_IMM) &&
                   (mode_i != CAG_AM_PC_REL8) && (mode_i != CAG_AM_PC_REL16);
    wire is_rmw  = (bit_op_i != CAG_BOP_NONE);
    wire is_imm  = (mode_i == CAG_AM_IMM);
    wire [31:0] imm_val = (size_i == CAG_SZ_BYTE) ? {24'h000000, ext_i[7:0]} :
                          (size_i == CAG_SZ_WORD) ? {16'h0000, ext_i[15:0]} : ext_i;

    // Bit modify of the read byte
    // Byte lane follows address bit 0
    wire [7:0] rd_byte  = ea_q[0] ? bc_rdata[7:0] : bc_rdata[15:8];
    wire [7:0] bit_mask = 8'h01 << bnum_q;
    logic [7:0] mod_byte;
    always_comb begin
        case (bop_q)
            CAG_BOP_SET:       mod_byte = rd_byte | bit_mask;
            CAG_BOP_CLEAR:     mod_byte = rd_byte & ~bit_mask;
            CAG_BOP_INVERT:    mod_byte = rd_byte ^ bit_mask;
            CAG_BOP_STORE:     mod_byte = carry_q ? (rd_byte | bit_mask) : (rd_byte & ~bit_mask);
            CAG_BOP_INV_STORE: mod_byte = carry_q ? (rd_byte & ~bit_mask) : (rd_byte | bit_mask);
            default:           mod_byte = rd_byte;
        endcase
    end

    // Bus sequencer requests
    logic        bc_req;
    logic        bc_we;
    logic        bc_word;
    logic [15:0] bc_addr;
    logic [15:0] bc_wdata;
    logic        bc_busy;
    logic        bc_done;

    wire issue = (seq_q != CAG_IDLE) && (seq_q != CAG_FINISH) && !bc_busy && !bc_done;

    always_comb begin
        bc_req   = 1'b0;
        bc_we    = 1'b0;
        bc_word  = 1'b0;
        bc_addr  = ea_q[15:0];
        bc_wdata = wdata_q;
        case (seq_q)
            CAG_ACCESS: begin
                bc_req  = issue;
                bc_we   = we_q && (bop_q == CAG_BOP_NONE);
                bc_word = word_q;
            end
            CAG_MIND_HI: begin
                bc_req  = issue;
                bc_word = 1'b1;
            end
            CAG_MIND_LO: begin
                bc_req  = issue;
                bc_word = 1'b1;
                bc_addr = ea_q[15:0] + 16'h0002;
            end
            CAG_RMW_WRITE: begin
                bc_req   = issue;
                bc_we    = 1'b1;
                bc_wdata = {mod_byte_q, mod_byte_q};
            end
            default: ;
        endcase
    end

    always_comb begin
        seq_d = seq_q;
        case (seq_q)
            CAG_IDLE: begin
                if (start_i && cpu_q == CAG_CPU_EXEC) begin
                    if (mode_i == CAG_AM_MEM_INDIRECT) begin
                        seq_d = CAG_MIND_HI;
                    end else if (is_mem) begin
                        seq_d = CAG_ACCESS;
                    end else begin
                        seq_d = CAG_FINISH;
                    end
                end
            end
            CAG_ACCESS:    if (bc_done) seq_d = (bop_q != CAG_BOP_NONE) ? CAG_RMW_WRITE : CAG_FINISH;
            CAG_MIND_HI:   if (bc_done) seq_d = CAG_MIND_LO;
            CAG_MIND_LO:   if (bc_done) seq_d = CAG_FINISH;
            CAG_RMW_WRITE: if (bc_done) seq_d = CAG_FINISH;
            default:       seq_d = CAG_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seq_q       <= CAG_IDLE;
            ea_q        <= 24'h000000;
            target_q    <= 24'h000000;
            ptr_wb_q    <= 32'h00000000;
            ptr_wb_en_q <= 1'b0;
            operand_q   <= 32'h00000000;
            imm_q       <= 32'h00000000;
            trap_q      <= 2'h0;
            done_q      <= 1'b0;
            we_q        <= 1'b0;
            word_q      <= 1'b0;
            wdata_q     <= 16'h0000;
            bop_q       <= CAG_BOP_NONE;
            bnum_q      <= 3'h0;
            carry_q     <= 1'b0;
            mode_sz_q   <= CAG_SZ_BYTE;
            post_q      <= 1'b0;
            mod_byte_q  <= 8'h00;
            tgt_hi_q    <= 8'h00;
        end else begin
            seq_q       <= seq_d;
            done_q      <= (seq_q == CAG_FINISH);
            ptr_wb_en_q <= 1'b0;
            if (seq_q == CAG_IDLE && seq_d != CAG_IDLE) begin
                ea_q      <= ea_calc;
                we_q      <= we_i && !is_rmw;
                word_q    <= (size_i != CAG_SZ_BYTE) && !is_rmw;
                wdata_q   <= wdata_i;
                bop_q     <= bit_op_i;
                bnum_q    <= bit_num_i;
                carry_q   <= carry_i;
                mode_sz_q <= size_i;
                post_q    <= (mode_i == CAG_AM_POST_INC);
                operand_q <= is_imm ? imm_val : reg_operand;
                imm_q     <= imm_val;
                trap_q    <= trap_opcode_i[5:4];
                if (mode_i == CAG_AM_PRE_DEC) begin
                    ptr_wb_q    <= ptr_dec;
                    ptr_wb_en_q <= 1'b1;
                end
                if (mode_i == CAG_AM_POST_INC) begin
                    ptr_wb_q <= ptr_inc;
                end
                if (mode_i == CAG_AM_PC_REL8 || mode_i == CAG_AM_PC_REL16) begin
                    target_q <= ea_calc;
                end
            end
            if (seq_q == CAG_ACCESS && bc_done) begin
                mod_byte_q <= mod_byte;
                operand_q  <= {16'h0000, bc_rdata};
            end
            if (seq_q == CAG_MIND_HI && bc_done) begin
                tgt_hi_q <= bc_rdata[7:0];
            end
            if (seq_q == CAG_MIND_LO && bc_done) begin
                target_q <= {tgt_hi_q, bc_rdata};
            end
            if (seq_q == CAG_FINISH && post_q) begin
                ptr_wb_en_q <= 1'b1;
            end
        end
    end

    // CPU top-level state
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpu_q <= CAG_CPU_RESET;
            sub_q <= CAG_SUB_ACTIVE;
        end else begin
            case (cpu_q)
                CAG_CPU_RESET: begin
                    cpu_q <= CAG_CPU_EXCEPT;
                end
                CAG_CPU_EXEC: begin
                    sub_q <= sub_clk_sel_i ? CAG_SUB_SUBACTIVE : CAG_SUB_ACTIVE;
                    if (except_req_i) begin
                        cpu_q <= CAG_CPU_EXCEPT;
                    end else if (halt_req_i && seq_q == CAG_IDLE) begin
                        cpu_q <= CAG_CPU_HALT;
                        sub_q <= halt_mode_i;
                    end
                end
                CAG_CPU_HALT: begin
                    if (wake_i) begin
                        cpu_q <= except_req_i ? CAG_CPU_EXCEPT : CAG_CPU_EXEC;
                        sub_q <= sub_clk_sel_i ? CAG_SUB_SUBACTIVE : CAG_SUB_ACTIVE;
                    end
                end
                default: begin
                    if (except_done_i) begin
                        cpu_q <= CAG_CPU_EXEC;
                    end
                end
            endcase
        end
    end

    cag_bus_cycle u_bus (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .state_en_i  (state_en_i),
        .req_i       (bc_req),
        .we_i        (bc_we),
        .word_i      (bc_word),
        .tgt_i       (bus_tgt_i),
        .addr_i      (bc_addr),
        .wdata_i     (bc_wdata),
        .busy_o      (bc_busy),
        .done_o      (bc_done),
        .rdata_o     (bc_rdata),
        .bus_addr_o  (bus_addr_o),
        .bus_wdata_o (bus_wdata_o),
        .bus_re_o    (bus_re_o),
        .bus_we_o    (bus_we_o),
        .bus_word_o  (bus_word_o),
        .bus_last_o  (),
        .bus_rdata_i (bus_rdata_i)
    );

    assign busy_o        = (seq_q != CAG_IDLE);
    assign done_o        = done_q;
    assign operand_o     = operand_q;
    assign ea_o          = ea_q;
    assign target_o      = target_q;
    assign ptr_wb_o      = ptr_wb_q;
    assign ptr_wb_en_o   = ptr_wb_en_q;
    assign imm_o         = imm_q;
    assign trap_vector_o = trap_q;
    assign rdata_o       = bc_rdata;
    assign cpu_state_o   = cpu_q;
    assign cpu_submode_o = sub_q;

endmodule // cag_core

// ==== cag_core_sva.sv ====
// Checker on the core's handshake and bus timing
`timescale 1ns/10ps
module cag_core_chk (
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire logic       busy_o,
    input wire logic       done_o,
    input wire logic       ptr_wb_en_o,
    input wire logic       bus_re_o,
    input wire logic       bus_we_o,
    input wire logic [1:0] cpu_state_o,
    input wire logic [1:0] cpu_submode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    done_pulse_a: assert property (done_o |=> !done_o) else $error("done too long");
    wb_pulse_a: assert property (ptr_wb_en_o |=> !ptr_wb_en_o) else $error("wb too long");
    rw_excl_a: assert property (!(bus_re_o && bus_we_o)) else $error("read and write");
    re_len_a: assert property ($rose(bus_re_o) |-> bus_re_o [*2]) else $error("short read");
    we_len_a: assert property ($rose(bus_we_o) |-> bus_we_o [*2]) else $error("short write");
    re_end_a: assert property ($rose(bus_re_o) |-> ##[2:40] !bus_re_o) else $error("read hung");
    done_busy_a: assert property (done_o |-> $past(busy_o)) else $error("done idle");
    exec_sub_a: assert property (cpu_state_o == 2'h1 |-> cpu_submode_o <= 2'h1)
        else $error("bad submode");
endmodule // cag_core_chk
bind cag_core cag_core_chk cag_core_chk_i (.clk_i(clk_i), .rstn_i(rstn_i), .busy_o(busy_o),
    .done_o(done_o), .ptr_wb_en_o(ptr_wb_en_o), .bus_re_o(bus_re_o), .bus_we_o(bus_we_o),
    .cpu_state_o(cpu_state_o), .cpu_submode_o(cpu_submode_o));

// ==== cag_mem_model.sv ====
// Memory and peripheral register model on the far side of the bus
`timescale 1ns/10ps
module cag_mem_model
    import cag_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        bus_re_i,
    input  wire logic        bus_we_i,
    input  wire logic        bus_word_i,
    input  wire logic [15:0] bus_addr_i,
    input  wire logic [15:0] bus_wdata_i,
    output logic      [15:0] bus_rdata_o,
    output logic      [1:0]  bus_tgt_o
);
    logic [7:0]  mem [0:65535];
    logic [15:0] last_q = 16'h0000;
    wire  [15:0] ev = {bus_addr_i[15:1], 1'b0};
    wire  [15:0] od = {bus_addr_i[15:1], 1'b1};
    wire         ok = bus_tgt_o != CAG_TGT_UNMAP;
    assign bus_tgt_o = (bus_addr_i[15:8] == 8'hFF) ? CAG_TGT_PER8 : (bus_addr_i[15:8] == 8'hFE)
        ? CAG_TGT_PER16 : (bus_addr_i[15:14] == 2'h2) ? CAG_TGT_UNMAP : CAG_TGT_MEM;
    assign bus_rdata_o = (bus_re_i && ok) ? {mem[ev], mem[od]} : ~last_q;
    initial for (int i = 0; i < 65536; i++) mem[i] = 8'h5A ^ i[7:0] ^ i[15:8];
    always @(posedge clk_i) begin
        last_q <= bus_rdata_o;
        if (bus_we_i && ok) begin
            if (bus_word_i || !bus_addr_i[0]) mem[ev] <= bus_wdata_i[15:8];
            if (bus_word_i || bus_addr_i[0]) mem[od] <= bus_wdata_i[7:0];
        end
    end
endmodule // cag_mem_model

// ==== testbench.sv ====
// Self-checking bench for address generation, bus cycles and bit modify
`timescale 1ns/10ps
module testbench import cag_pkg::*;;
    logic        clk_i = 0, rstn_i = 0, st_en = 1, start = 0, we = 0, cy = 0, xd = 0;
    logic        busy, done, wben, bre, bwe, bw;
    logic [1:0]  sz = 0, hm = 0, tv, cs, csm, tg;
    logic [2:0]  bop = 0, bn = 0;
    logic [3:0]  rs = 0;
    logic [7:0]  top = 0, b, m;
    logic [15:0] wd = 0, rd, ba, bwd, rdi, a;
    logic [15:0] at [4] = '{16'h1234, 16'hFE10, 16'hFF20, 16'h9000};
    logic [23:0] pc = 0, tgo, ea, e;
    logic [31:0] p = 0, x = 0, s, opd, wb, imm;
    cag_mode_t   md = CAG_AM_REG_INDIRECT;
    int          num_errors = 0, n_compared = 0, k;
    cag_core cag_core_i (.clk_i(clk_i), .rstn_i(rstn_i), .state_en_i(st_en), .sub_clk_sel_i(1'b0),
        .start_i(start), .mode_i(md), .size_i(sz), .reg_sel_i(rs), .pointer_register_i(p),
        .ext_i(x), .pc_i(pc), .we_i(we), .wdata_i(wd), .bit_op_i(bop), .bit_num_i(bn),
        .carry_i(cy), .trap_opcode_i(top), .tgt_i(2'h0), .halt_req_i(1'b0), .halt_mode_i(hm),
        .wake_i(1'b0), .except_req_i(1'b0), .except_done_i(xd), .busy_o(busy), .done_o(done),
        .operand_o(opd), .ea_o(ea), .target_o(tgo), .ptr_wb_o(wb), .ptr_wb_en_o(wben),
        .imm_o(imm), .trap_vector_o(tv), .rdata_o(rd), .bus_addr_o(ba), .bus_wdata_o(bwd),
        .bus_re_o(bre), .bus_we_o(bwe), .bus_word_o(bw), .bus_rdata_i(rdi), .bus_tgt_i(tg),
        .cpu_state_o(cs), .cpu_submode_o(csm));
    cag_mem_model cag_mem_model_i (.clk_i(clk_i), .bus_re_i(bre), .bus_we_i(bwe),
        .bus_word_i(bw), .bus_addr_i(ba), .bus_wdata_i(bwd), .bus_rdata_o(rdi), .bus_tgt_o(tg));
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) st_en <= ($urandom % 4) != 0;
    task automatic chk(input string n, input logic [31:0] xp, input logic [31:0] got);
        n_compared++;
        if (got !== xp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, xp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic go;
        start <= 1'b1;
        @(posedge clk_i) start <= 1'b0;
        for (k = 0; k < 300 && done !== 1'b1; k++) @(negedge clk_i);
        if (done !== 1'b1) begin
            chk("done", 1, 0);
            report_and_stop;
        end
    endtask
    initial begin
        void'($urandom(44));
        repeat (5) @(negedge clk_i);
        chk("reset_state", 0, {cs, ea});
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        xd <= 1'b1;
        for (k = 0; k < 50 && cs !== 2'h1; k++) @(negedge clk_i);
        chk("cpu_state", 1, cs);
        for (int i = 0; i < 39; i++) begin
            @(posedge clk_i);
            md <= cag_mode_t'(i % 13);
            sz <= 2'(i % 3);
            p <= $urandom & 32'hFFFF_FFFE;
            x <= $urandom & 32'hFFFF_FFFE;
            pc <= 24'($urandom) & 24'hFF_FFFE;
            {rs, hm, top} <= 14'($urandom);
            go;
            s = 32'h1 << sz;
            a = {8'h00, x[7:0]};
            case (md)
                CAG_AM_DISP16: e = p[23:0] + {{8{x[15]}}, x[15:0]};
                CAG_AM_DISP24: e = p[23:0] + x[23:0];
                CAG_AM_PRE_DEC: e = p[23:0] - s[23:0];
                CAG_AM_ABS8: e = {16'hFFFF, x[7:0]};
                CAG_AM_ABS16: e = {{8{x[15]}}, x[15:0]};
                CAG_AM_ABS24: e = x[23:0];
                CAG_AM_PC_REL8: e = pc + {{16{x[7]}}, x[7:0]};
                CAG_AM_PC_REL16: e = pc + {{8{x[15]}}, x[15:0]};
                CAG_AM_MEM_INDIRECT: e = {8'h00, a};
                default: e = p[23:0];
            endcase
            if (md == CAG_AM_PC_REL8 || md == CAG_AM_PC_REL16) chk("target", e, tgo);
            else if (md != CAG_AM_REG_DIRECT && md != CAG_AM_IMM) chk("ea", e, ea);
            if (md == CAG_AM_IMM) chk("imm", sz[1] ? x : sz ? x[15:0] : x[7:0], imm);
            if (md == CAG_AM_REG_DIRECT) chk("operand", sz[1] ? p : sz ? (rs[3] ? p[31:16]
                : p[15:0]) : rs[3] ? p[7:0] : p[15:8], opd);
            chk("trap", top[5:4], tv);
            if (md == CAG_AM_POST_INC) chk("ptr_wb", p + s, wb);
            if (md == CAG_AM_PRE_DEC) chk("ptr_wb", p - s, wb);
            if (md == CAG_AM_MEM_INDIRECT) chk("target", {cag_mem_model_i.mem[a + 16'h1],
                cag_mem_model_i.mem[a + 16'h2], cag_mem_model_i.mem[a + 16'h3]}, tgo);
        end
        foreach (at[j]) begin
            @(posedge clk_i);
            md <= CAG_AM_ABS16;
            sz <= CAG_SZ_WORD;
            x <= {16'h0000, at[j]};
            we <= 1'b1;
            wd <= 16'($urandom);
            go;
            @(posedge clk_i);
            we <= 1'b0;
            go;
            chk("rdata", (at[j][15:14] == 2'h2) ? 16'h0000 : wd, rd);
        end
        for (int o = 1; o < 6; o++) begin
            a = 16'h2000 + 16'(o);
            b = cag_mem_model_i.mem[a];
            @(posedge clk_i);
            sz <= CAG_SZ_BYTE;
            x <= {16'h0000, a};
            bop <= 3'(o);
            {bn, cy} <= 4'($urandom);
            go;
            m = 8'h01 << bn;
            b = (o == 1) ? b | m : (o == 2) ? b & ~m : (o == 3) ? b ^ m
                : ((o == 4) == cy) ? b | m : b & ~m;
            chk("bit_byte", b, cag_mem_model_i.mem[a]);
        end
        report_and_stop;
    end
endmodule // testbench
